//--- rtl/uhirq_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "uhirq_map.svh"

module uhirq_regs
   import uhirq_pkg::*;
#(
   parameter int unsigned FS_LEN_CYC = `UHI_FS_LEN_CYC,
   parameter int unsigned HS_LEN_CYC = `UHI_HS_LEN_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire uhirq_bus_req_type bus_req_in,
   output logic [31:0] bus_rdata_out,
   input wire logic [31:0] host_irq_flag_in,
   input wire logic hs_mode_in,
   input wire logic sof_run_in,
   input wire logic usb_reset_req_in,
   output logic [31:0] host_irq_en_out,
   output logic [55:0] pipe_dev_addr_out,
   output uhirq_frame_type frame_out,
   output logic ctrl_irq_out
);

   logic [31:0] host_irq_enable_reg;
   logic [31:0] next_host_irq_enable_reg;
   logic [6:0] pipe_addr [8];
   logic [6:0] next_pipe_addr [8];
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic wr_clr;
   logic wr_set;
   logic wr_frame;
   logic wr_lo;
   logic wr_hi;
   uhirq_frame_type frame;

   // ==========================================================
   // Address decode.
   always_comb
   begin
      wr_clr = 1'b0;
      wr_set = 1'b0;
      wr_frame = 1'b0;
      wr_lo = 1'b0;
      wr_hi = 1'b0;
      if (!bus_req_in.wr)
      begin
         wr_clr = 1'b0;
      end
      else if (bus_req_in.addr == `UHI_OFS_EN_CLR)
      begin
         wr_clr = 1'b1;
      end
      else if (bus_req_in.addr == `UHI_OFS_EN_SET)
      begin
         wr_set = 1'b1;
      end
      else if (bus_req_in.addr == `UHI_OFS_FRAME)
      begin
         wr_frame = 1'b1;
      end
      else if (bus_req_in.addr == `UHI_OFS_ADDR_LO)
      begin
         wr_lo = 1'b1;
      end
      else if (bus_req_in.addr == `UHI_OFS_ADDR_HI)
      begin
         wr_hi = 1'b1;
      end
   end

   // ==========================================================
   // Interrupt enable register.
   // Set and clear arrive on separate strobes, so they never
   // collide; bits with no source are masked so they stay zero.
   always_comb
   begin
      next_host_irq_enable_reg = host_irq_enable_reg;
      if (wr_clr)
      begin
         next_host_irq_enable_reg = host_irq_enable_reg
            & ~(bus_req_in.wdata & `UHI_EN_MASK);
      end
      else if (wr_set)
      begin
         next_host_irq_enable_reg = host_irq_enable_reg
            | (bus_req_in.wdata & `UHI_EN_MASK);
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         host_irq_enable_reg <= `UHI_EN_RST;
      end
      else
      begin
         host_irq_enable_reg <= next_host_irq_enable_reg;
      end
   end

   assign host_irq_en_out = host_irq_enable_reg;

   // The flag register lives elsewhere; gating is kept
   // combinational so the request follows a flag or enable
   // change in the same cycle.
   assign ctrl_irq_out = |(host_irq_flag_in & host_irq_enable_reg);

   // ==========================================================
   // Pipe device addresses.
   // A bus reset request outranks a write in the same cycle,
   // since the attached device is about to lose its address.
   for (genvar g = 0; g < 8; g++)
   begin : g_pipe
      logic sel;
      assign sel = (g < 4) ? wr_lo : wr_hi;
      always_comb
      begin
         next_pipe_addr[g] = pipe_addr[g];
         if (usb_reset_req_in)
         begin
            next_pipe_addr[g] = `UHI_ADDR_RST;
         end
         else if (sel)
         begin
            next_pipe_addr[g] = bus_req_in.wdata[8*(g%4) +: 7];
         end
      end
      always_ff @(posedge clk_sys_in)
      begin
         if (sys_rst_in)
         begin
            pipe_addr[g] <= `UHI_ADDR_RST;
         end
         else
         begin
            pipe_addr[g] <= next_pipe_addr[g];
         end
      end
      assign pipe_dev_addr_out[7*g +: 7] = pipe_addr[g];
   end

   // ==========================================================
   // Frame number.
   uhirq_frame #(
      .FS_LEN_CYC(FS_LEN_CYC),
      .HS_LEN_CYC(HS_LEN_CYC)
   ) u_frame (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .hs_mode_in(hs_mode_in),
      .sof_run_in(sof_run_in),
      .frame_index_wr_in(wr_frame),
      .frame_index_wdata_in(bus_req_in.wdata[13:3]),
      .frame_out(frame)
   );

   assign frame_out = frame;

   // ==========================================================
   // Read data.
   // Write-only ports and unmapped offsets answer zero.
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (!bus_req_in.rd)
      begin
         next_rdata = 32'h0000_0000;
      end
      else if (bus_req_in.addr == `UHI_OFS_EN)
      begin
         next_rdata = host_irq_enable_reg;
      end
      else if (bus_req_in.addr == `UHI_OFS_FRAME)
      begin
         next_rdata[`UHI_FRM_FLEN_LSB +: 8] = frame.flen_high;
         next_rdata[`UHI_FRM_FRAME_INDEX_LSB +: 11] = frame.frame_index;
         next_rdata[`UHI_FRM_MF_LSB +: 3] = frame.micro_frame_index;
      end
      else if (bus_req_in.addr == `UHI_OFS_ADDR_LO)
      begin
         next_rdata = {1'b0, pipe_addr[3], 1'b0, pipe_addr[2],
                       1'b0, pipe_addr[1], 1'b0, pipe_addr[0]};
      end
      else if (bus_req_in.addr == `UHI_OFS_ADDR_HI)
      begin
         next_rdata = {1'b0, pipe_addr[7], 1'b0, pipe_addr[6],
                       1'b0, pipe_addr[5], 1'b0, pipe_addr[4]};
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end

   assign bus_rdata_out = rdata;

   // ==========================================================
   // Checks.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   property p_rx_set;
      wr_set && bus_req_in.wdata[`UHI_SRC_RXRSM]
         |=> host_irq_enable_reg[`UHI_SRC_RXRSM];
   endproperty
   a_rx_set: assert property (p_rx_set)
      else $error("Resume-received enable not set.");

   property p_rsmed_clr;
      wr_clr && bus_req_in.wdata[`UHI_SRC_RSMED]
         |=> !host_irq_enable_reg[`UHI_SRC_RSMED];
   endproperty
   a_rsmed_clr: assert property (p_rsmed_clr)
      else $error("Resume-sent enable not cleared.");

   property p_rst_set_clr;
      wr_set && bus_req_in.wdata[`UHI_SRC_RST]
         ##1 wr_clr && bus_req_in.wdata[`UHI_SRC_RST]
         |-> host_irq_enable_reg[`UHI_SRC_RST]
         ##1 !host_irq_enable_reg[`UHI_SRC_RST];
   endproperty
   a_rst_set_clr: assert property (p_rst_set_clr)
      else $error("Reset-sent enable did not follow set then clear.");

   property p_ddisc_clr;
      wr_clr && bus_req_in.wdata[`UHI_SRC_DDISC]
         |=> !host_irq_enable_reg[`UHI_SRC_DDISC];
   endproperty
   a_ddisc_clr: assert property (p_ddisc_clr)
      else $error("Detach enable not cleared.");

   property p_dconn_set;
      wr_set && bus_req_in.wdata[`UHI_SRC_DCONN]
         |=> host_irq_enable_reg[`UHI_SRC_DCONN];
   endproperty
   a_dconn_set: assert property (p_dconn_set)
      else $error("Attach enable not set.");

   property p_clr_zero;
      (wr_clr || wr_set) && bus_req_in.wdata == 32'h0000_0000
         |=> $stable(host_irq_enable_reg);
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("Zero write changed the enable register.");

   property p_clr_read;
      bus_req_in.rd && (bus_req_in.addr == `UHI_OFS_EN_CLR
         || bus_req_in.addr == `UHI_OFS_EN_SET)
         |=> bus_rdata_out == 32'h0000_0000;
   endproperty
   a_clr_read: assert property (p_clr_read)
      else $error("Write-only port read nonzero.");

   property p_set_only;
      wr_set |=> (host_irq_enable_reg & ~$past(host_irq_enable_reg))
         == ($past(bus_req_in.wdata) & `UHI_EN_MASK
             & ~$past(host_irq_enable_reg));
   endproperty
   a_set_only: assert property (p_set_only)
      else $error("Set port changed unexpected bits.");

   property p_reserved;
      (host_irq_enable_reg & ~`UHI_EN_MASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved enable bit became one.");

   property p_frame_index_read;
      bus_req_in.rd && bus_req_in.addr == `UHI_OFS_FRAME
         |=> bus_rdata_out[13:3] == $past(frame.frame_index);
   endproperty
   a_frame_index_read: assert property (p_frame_index_read)
      else $error("Frame number read in wrong place.");

   property p_frame_index_wr;
      wr_frame |=> frame.micro_frame_index == 3'h0
         && frame.frame_index == $past(bus_req_in.wdata[13:3]);
   endproperty
   a_frame_index_wr: assert property (p_frame_index_wr)
      else $error("Frame number write did not zero micro-frame.");

   property p_addr_lo;
      wr_lo && !usb_reset_req_in
         |=> pipe_addr[0] == $past(bus_req_in.wdata[6:0])
         && pipe_addr[3] == $past(bus_req_in.wdata[30:24]);
   endproperty
   a_addr_lo: assert property (p_addr_lo)
      else $error("Low address register not written.");

   property p_addr_hi;
      wr_hi && !usb_reset_req_in
         |=> pipe_addr[4] == $past(bus_req_in.wdata[6:0])
         && pipe_addr[7] == $past(bus_req_in.wdata[30:24]);
   endproperty
   a_addr_hi: assert property (p_addr_hi)
      else $error("High address register not written.");

   property p_addr_rst;
      usb_reset_req_in |=> pipe_dev_addr_out == 56'h0;
   endproperty
   a_addr_rst: assert property (p_addr_rst)
      else $error("Bus reset request left a pipe address.");

   property p_irq_gate;
      (host_irq_flag_in & host_irq_enable_reg) == 32'h0000_0000
         |-> !ctrl_irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("Interrupt raised by a disabled flag.");

   property p_irq_on;
      host_irq_flag_in[`UHI_SRC_DCONN]
         && host_irq_enable_reg[`UHI_SRC_DCONN] |-> ctrl_irq_out;
   endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("Enabled flag did not raise the interrupt.");

   c_set_then_irq: cover property (wr_set ##1 ctrl_irq_out);
   c_addr_reset: cover property (wr_lo ##1 usb_reset_req_in);
   c_frame_wr: cover property (wr_frame && hs_mode_in);

endmodule : uhirq_regs
`default_nettype wire

//--- rtl/uhirq_map.svh
`ifndef UHIRQ_MAP_SVH
`define UHIRQ_MAP_SVH

// ==========================================================
// Register map.
`define UHI_AW 12
`define UHI_OFS_EN 12'h410
`define UHI_OFS_EN_CLR 12'h414
`define UHI_OFS_EN_SET 12'h418
`define UHI_OFS_FRAME 12'h420
`define UHI_OFS_ADDR_LO 12'h424
`define UHI_OFS_ADDR_HI 12'h428

// ==========================================================
// Field layout and reset values.
`define UHI_EN_MASK 32'hfe00_ff7f
`define UHI_EN_RST 32'h0000_0000
`define UHI_ADDR_RST 7'h00
`define UHI_FRM_FLEN_LSB 16
`define UHI_FRM_FRAME_INDEX_LSB 3
`define UHI_FRM_MF_LSB 0
`define UHI_SRC_DCONN 0
`define UHI_SRC_DDISC 1
`define UHI_SRC_RST 2
`define UHI_SRC_RSMED 3
`define UHI_SRC_RXRSM 4

// ==========================================================
// Frame timing.
`define UHI_CLK_PERIOD_NS 25
`define UHI_FS_FRAME_MS 1
`define UHI_HS_FRAME_US 125
`define UHI_FS_LEN_CYC (`UHI_FS_FRAME_MS * 1000000 / `UHI_CLK_PERIOD_NS)
`define UHI_HS_LEN_CYC (`UHI_HS_FRAME_US * 1000 / `UHI_CLK_PERIOD_NS)

`endif

//--- rtl/uhirq_pkg.sv
`default_nettype none
`include "uhirq_map.svh"

package uhirq_pkg;

   typedef struct packed {
      logic [`UHI_AW-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } uhirq_bus_req_type;

   typedef struct packed {
      logic [7:0] flen_high;
      logic [10:0] frame_index;
      logic [2:0] micro_frame_index;
   } uhirq_frame_type;

endpackage : uhirq_pkg
`default_nettype wire

//--- rtl/uhirq_frame.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhirq_map.svh"

module uhirq_frame
   import uhirq_pkg::*;
#(
   parameter int unsigned FS_LEN_CYC = `UHI_FS_LEN_CYC,
   parameter int unsigned HS_LEN_CYC = `UHI_HS_LEN_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic hs_mode_in,
   input wire logic sof_run_in,
   input wire logic frame_index_wr_in,
   input wire logic [10:0] frame_index_wdata_in,
   output uhirq_frame_type frame_out
);

   logic [15:0] cnt;
   logic [10:0] frame_index;
   logic [2:0] micro_frame_index;
   logic [15:0] next_cnt;
   logic [10:0] next_frame_index;
   logic [2:0] next_micro_frame_index;
   logic [15:0] last_cnt;
   logic wrap;

   // ==========================================================
   // Frame counter.
   // The counter runs on the system clock, so its length is
   // derived from the frame time rather than the 30 MHz figure.
   always_comb
   begin
      last_cnt = hs_mode_in ? 16'(HS_LEN_CYC - 1) : 16'(FS_LEN_CYC - 1);
      wrap = sof_run_in && (cnt >= last_cnt);
      next_cnt = cnt;
      next_frame_index = frame_index;
      next_micro_frame_index = micro_frame_index;
      if (wrap)
      begin
         next_cnt = 16'h0000;
         if (hs_mode_in)
         begin
            next_micro_frame_index = micro_frame_index + 3'h1;
            if (micro_frame_index == 3'h7)
            begin
               next_frame_index = frame_index + 11'h001;
            end
         end
         else
         begin
            next_frame_index = frame_index + 11'h001;
         end
      end
      else if (sof_run_in)
      begin
         next_cnt = cnt + 16'h0001;
      end
      if (!hs_mode_in)
      begin
         next_micro_frame_index = 3'h0;
      end
      if (frame_index_wr_in)
      begin
         next_frame_index = frame_index_wdata_in;
         next_micro_frame_index = 3'h0;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         cnt <= 16'h0000;
         frame_index <= 11'h000;
         micro_frame_index <= 3'h0;
      end
      else
      begin
         cnt <= next_cnt;
         frame_index <= next_frame_index;
         micro_frame_index <= next_micro_frame_index;
      end
   end

   assign frame_out.flen_high = cnt[15:8];
   assign frame_out.frame_index = frame_index;
   assign frame_out.micro_frame_index = micro_frame_index;

   // ==========================================================
   // Checks.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   property p_fs_len;
      !hs_mode_in && $past(!hs_mode_in) |-> cnt < 16'(FS_LEN_CYC);
   endproperty
   a_fs_len: assert property (p_fs_len)
      else $error("Full-speed frame counter exceeded its length.");

   property p_hs_len;
      hs_mode_in && $past(hs_mode_in) && $past(cnt < 16'(HS_LEN_CYC))
         |-> cnt < 16'(HS_LEN_CYC);
   endproperty
   a_hs_len: assert property (p_hs_len)
      else $error("High-speed frame counter exceeded its length.");

   property p_mf_step;
      hs_mode_in && wrap && !frame_index_wr_in |=> micro_frame_index == 3'($past(micro_frame_index) + 3'h1);
   endproperty
   a_mf_step: assert property (p_mf_step)
      else $error("Micro-frame number did not advance.");

   property p_mf_fs_zero;
      !hs_mode_in && $past(!hs_mode_in) |-> micro_frame_index == 3'h0;
   endproperty
   a_mf_fs_zero: assert property (p_mf_fs_zero)
      else $error("Micro-frame number nonzero in full speed.");

   c_hs_wrap: cover property (hs_mode_in && wrap && micro_frame_index == 3'h7);

endmodule : uhirq_frame
`default_nettype wire

//--- verif/uhirq_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far side of the host port: a peripheral whose events land as flags.
// The flag register is kept here because it lies outside the block.
module uhirq_periph_model
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [31:0] ev_set_in,
   input wire logic [31:0] ev_clr_in,
   input wire logic hs_dev_in,
   output logic [31:0] flag_out,
   output logic hs_out
);
   logic [31:0] next_flag;
   logic next_hs;

   // Set wins over clear so that an event in the clearing cycle is kept.
   always_comb
   begin
      next_flag = (flag_out & ~ev_clr_in) | ev_set_in;
      next_hs = hs_dev_in;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         flag_out <= 32'h0;
         hs_out <= 1'b0;
      end
      else
      begin
         flag_out <= next_flag;
         hs_out <= next_hs;
      end
   end
endmodule : uhirq_periph_model

`default_nettype wire

//--- verif/uhirq_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhirq_map.svh"

module uhirq_regs_bench
   import uhirq_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   uhirq_bus_req_type bus_req = '0;
   logic [31:0] rdata, flag, en, ev_set = 32'h0, ev_clr = 32'h0;
   logic hs, hs_dev = 1'b0, sof_run = 1'b0, usb_rst = 1'b0, irq;
   logic [55:0] paddr;
   uhirq_frame_type frame;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   // Short frame lengths keep the run brief; 600 still lets the high
   // byte of the counter move.
   uhirq_regs #(.FS_LEN_CYC(600), .HS_LEN_CYC(8)) dut (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .bus_req_in(bus_req), .bus_rdata_out(rdata),
      .host_irq_flag_in(flag), .hs_mode_in(hs), .sof_run_in(sof_run),
      .usb_reset_req_in(usb_rst), .host_irq_en_out(en),
      .pipe_dev_addr_out(paddr), .frame_out(frame), .ctrl_irq_out(irq));

   uhirq_periph_model peer (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .ev_set_in(ev_set), .ev_clr_in(ev_clr), .hs_dev_in(hs_dev),
      .flag_out(flag), .hs_out(hs));

   always #12.5 clk_sys_in = ~clk_sys_in;

   // ==========================================================
   // Shared tasks.
   task automatic end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick;
      @(posedge clk_sys_in);
   endtask : tick

   // Read data are sampled mid-cycle, away from the edges that launch
   // and retire them, so no ordering within an edge matters.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      tick;
      bus_req <= '0;
      @(negedge clk_sys_in);
      chk({24'h0, rdata}, {24'h0, exp});
      tick;
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick;
      bus_req <= '0;
      tick;
   endtask : wr

   task automatic flags(input logic [31:0] s, input logic [31:0] c);
      ev_set <= s;
      ev_clr <= c;
      tick;
      ev_set <= 32'h0;
      ev_clr <= 32'h0;
      tick;
   endtask : flags

   task automatic run(input int n);
      sof_run <= 1'b1;
      repeat (n) tick;
      sof_run <= 1'b0;
      tick;
   endtask : run

   function automatic logic [31:0] fx(input logic [7:0] fl,
      input logic [10:0] fn, input logic [2:0] mf);
      return {8'h0, fl, 2'b00, fn, mf};
   endfunction : fx

   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         end_sim;
      end
   end

   // ==========================================================
   // Test sequence.
   initial
   begin
      repeat (12) tick;
      sys_rst_in <= 1'b0;
      tick;
      rd(`UHI_OFS_EN, 32'h0);
      rd(`UHI_OFS_FRAME, 32'h0);
      rd(`UHI_OFS_ADDR_LO, 32'h0);
      rd(`UHI_OFS_ADDR_HI, 32'h0);
      flags(32'h0000_001f, 32'h0);
      chk(irq, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         wr(`UHI_OFS_EN_SET, 32'h1 << i);
         chk(en, 32'h1 << i);
         chk(irq, 1'b1);
         wr(`UHI_OFS_EN_CLR, 32'h1 << i);
         chk(en, 32'h0);
         chk(irq, 1'b0);
      end
      bus_req <= '{addr: `UHI_OFS_EN_SET, wdata: 32'h4, wr: 1'b1,
         rd: 1'b0};
      tick;
      bus_req <= '{addr: `UHI_OFS_EN_CLR, wdata: 32'h4, wr: 1'b1,
         rd: 1'b0};
      @(negedge clk_sys_in);
      chk(en, 32'h4);
      chk(irq, 1'b1);
      tick;
      bus_req <= '0;
      tick;
      chk(en, 32'h0);
      wr(`UHI_OFS_EN_SET, 32'hffff_ffff);
      rd(`UHI_OFS_EN, 32'hfe00_ff7f);
      wr(`UHI_OFS_EN_CLR, 32'h0);
      rd(`UHI_OFS_EN, 32'hfe00_ff7f);
      wr(`UHI_OFS_EN_CLR, 32'h0000_ff00);
      rd(`UHI_OFS_EN, 32'hfe00_007f);
      rd(`UHI_OFS_EN_CLR, 32'h0);
      rd(`UHI_OFS_EN_SET, 32'h0);
      rd(12'h41c, 32'h0);
      flags(32'h0000_8080, 32'hffff_ffff);
      chk(irq, 1'b0);
      wr(`UHI_OFS_EN_SET, 32'h0000_8000);
      chk(irq, 1'b1);
      flags(32'h0, 32'h0000_8000);
      chk(irq, 1'b0);
      wr(`UHI_OFS_ADDR_LO, 32'h8483_8281);
      wr(`UHI_OFS_ADDR_HI, 32'h0877_6655);
      rd(`UHI_OFS_ADDR_LO, 32'h0403_0201);
      rd(`UHI_OFS_ADDR_HI, 32'h0877_6655);
      chk(paddr, {7'h08, 7'h77, 7'h66, 7'h55,
         7'h04, 7'h03, 7'h02, 7'h01});
      bus_req <= '{addr: `UHI_OFS_ADDR_LO, wdata: 32'h7f7f_7f7f,
         wr: 1'b1, rd: 1'b0};
      usb_rst <= 1'b1;
      tick;
      bus_req <= '0;
      usb_rst <= 1'b0;
      tick;
      rd(`UHI_OFS_ADDR_LO, 32'h0);
      rd(`UHI_OFS_ADDR_HI, 32'h0);
      chk(paddr, 56'h0);
      wr(`UHI_OFS_FRAME, 32'h00ff_2d2f);
      rd(`UHI_OFS_FRAME, fx(8'h00, 11'h5a5, 3'h0));
      chk(frame.frame_index, 11'h5a5);
      hs_dev <= 1'b1;
      tick;
      tick;
      run(72);
      rd(`UHI_OFS_FRAME, fx(8'h00, 11'h5a6, 3'h1));
      wr(`UHI_OFS_FRAME, 32'h0000_0088);
      rd(`UHI_OFS_FRAME, fx(8'h00, 11'h011, 3'h0));
      run(8);
      chk(frame.micro_frame_index, 3'h1);
      hs_dev <= 1'b0;
      tick;
      tick;
      rd(`UHI_OFS_FRAME, fx(8'h00, 11'h011, 3'h0));
      run(300);
      rd(`UHI_OFS_FRAME, fx(8'h01, 11'h011, 3'h0));
      chk(frame.flen_high, 8'h01);
      run(300);
      rd(`UHI_OFS_FRAME, fx(8'h00, 11'h012, 3'h0));
      end_sim;
   end
endmodule : uhirq_regs_bench

`default_nettype wire
